// [tkd_pkg.sv]
package tkd_pkg;
   localparam int SIG_W = 16;
   localparam int NKEY  = 16;
   localparam int KEY_W = 4;
   localparam int TH_W  = 8;
   localparam int DLY_W = 8;
   localparam int ADDR_W = 12;

   // full calibration length in bursts
   localparam logic [3:0] CAL_BURSTS = 4'h9;

   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_DETECT = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_CALIB  = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_KCFG   = 12'h100;
   localparam logic [ADDR_W-1:0] ADDR_KDLY   = 12'h140;
   localparam logic [ADDR_W-1:0] ADDR_KST    = 12'h180;

   // control field positions
   localparam int CTRL_HN_LSB    = 0;
   localparam int CTRL_HP_LSB    = 2;
   localparam int CTRL_RECAL_BIT = 4;

   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] KCFG_RST = 32'h0412_0a14;
   localparam logic [31:0] KDLY_RST = 32'h0000_0420;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      H_EIGHTH  = 2'h0,
      H_QUARTER = 2'h1,
      H_HALF    = 2'h2
   } tkd_hyst_e;

   typedef enum logic [1:0] {
      KS_CAL  = 2'h0,
      KS_IDLE = 2'h1,
      KS_PEND = 2'h3,
      KS_ON   = 2'h2
   } tkd_kst_e;

   typedef enum logic [2:0] {
      RG_CTRL, RG_DET, RG_CAL, RG_KCFG, RG_KDLY, RG_KST, RG_NONE
   } tkd_rgn_e;

   typedef struct packed {
      logic [KEY_W-1:0] key;
      logic [SIG_W-1:0] value;
   } tkd_sample_s;

   typedef struct packed {
      logic [2:0]      rsvd;
      logic            drift_off;
      logic [3:0]      drift_dn;
      logic [3:0]      drift_up;
      logic [3:0]      integ;
      logic [TH_W-1:0] pthr;
      logic [TH_W-1:0] nthr;
   } tkd_kcfg_s;

   typedef struct packed {
      logic [15:0]      rsvd;
      logic [DLY_W-1:0] pdly;
      logic [DLY_W-1:0] ndly;
   } tkd_kdly_s;
endpackage : tkd_pkg

// [tkd_touch_key.sv]
// How it works
// - hysteresis of one eighth, quarter or half
// - drop-out sits between threshold and reference
// - separate global negative and positive hysteresis
// - idle reference slews one step toward signal
// - levels recomputed from current reference
// - no drift once below negative threshold
// - separate up and down drift rates
// - per-key drift rate, per-key drift disable
// - recalibrate when detection outlasts negative delay
// - negative delay per key, zero disables
// - integrator counts up, confirms at target
// - failed sample before target clears integrator
// - release counts down, off at zero
// - target zero disables detection, bursts continue
// - sixteen integrator target values per key
// - sustained positive swing loads reference with signal
// - positive delay per key, zero disables
// - touch is a falling signal
// - negative threshold is per-key offset below reference
// - positive threshold per-key offset above reference
// - full calibration takes nine bursts
`timescale 1ns/1ps
module tkd_touch_key
   import tkd_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // samples from the conversion front end
   input  wire logic              smp_valid,
   input  wire tkd_sample_s       smp,
   // key status
   output logic [NKEY-1:0]        detect_o,
   output logic [NKEY-1:0]        calib_o,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int SX = SIG_W + 2;

   function automatic tkd_rgn_e decode(input logic [ADDR_W-1:0] a);
      if (a == ADDR_CTRL) decode = RG_CTRL;
      else if (a == ADDR_DETECT) decode = RG_DET;
      else if (a == ADDR_CALIB) decode = RG_CAL;
      else if (a[ADDR_W-1:6] == ADDR_KCFG[ADDR_W-1:6]) decode = RG_KCFG;
      else if (a[ADDR_W-1:6] == ADDR_KDLY[ADDR_W-1:6]) decode = RG_KDLY;
      else if (a[ADDR_W-1:6] == ADDR_KST[ADDR_W-1:6]) decode = RG_KST;
      else decode = RG_NONE;
   endfunction : decode

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
      for (int b = 0; b < 4; b++)
         o[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
      merge = o;
   endfunction : merge

   // portion of the threshold distance given back on drop-out
   function automatic logic [TH_W-1:0] hyst_part(input logic [TH_W-1:0] d,
                                                 input logic [1:0]      h);
      case (h)
         H_EIGHTH:  hyst_part = d >> 3;
         H_QUARTER: hyst_part = d >> 2;
         default:   hyst_part = d >> 1;
      endcase
   endfunction : hyst_part

   // configuration
   logic [1:0]       hn_reg;
   logic [1:0]       hp_reg;
   logic             recal_req_reg;
   tkd_kcfg_s        kcfg_reg [NKEY];
   tkd_kdly_s        kdly_reg [NKEY];
   // per-key state
   logic [SIG_W-1:0] ref_reg  [NKEY];
   logic [3:0]       cnt_reg  [NKEY];
   tkd_kst_e         kst_reg  [NKEY];
   logic [DLY_W-1:0] ntim_reg [NKEY];
   logic [DLY_W-1:0] ptim_reg [NKEY];
   logic [3:0]       dcnt_reg [NKEY];
   logic [3:0]       calc_reg [NKEY];
   logic [NKEY-1:0]  detect_reg;
   logic [NKEY-1:0]  calib_reg;
   // bus
   logic             awready_reg, wready_reg, bvalid_reg;
   logic             arready_reg, rvalid_reg;
   logic [1:0]       bresp_reg, rresp_reg;
   logic [31:0]      rdata_reg;
   logic             aw_got_reg, w_got_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0]      wdata_reg;
   logic [3:0]       wstrb_reg;
   logic             wr_fire;
   tkd_rgn_e         wr_rgn;
   logic [KEY_W-1:0] wr_key;

   assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   assign wr_rgn  = decode(awaddr_reg);
   assign wr_key  = awaddr_reg[2 +: KEY_W];

   // per-sample evaluation of the addressed key
   tkd_kcfg_s        cfg;
   tkd_kdly_s        dly;
   logic [SIG_W-1:0] ref_c, ref_n;
   logic [3:0]       cnt_c, cnt_n, dcnt_c, dcnt_n, calc_c, calc_n, rate;
   tkd_kst_e         kst_c, kst_n;
   logic [DLY_W-1:0] ntim_c, ntim_n, ptim_c, ptim_n;
   logic signed [SX-1:0] sig_x, ref_x, nd_x, pd_x, nh_x, ph_x;
   logic signed [SX-1:0] neg_lvl, neg_drop, pos_lvl, pos_drop;
   logic             below_n, still_n, above_p, still_p;
   logic             neg_fire, pos_fire;

   assign cfg    = kcfg_reg[smp.key];
   assign dly    = kdly_reg[smp.key];
   assign ref_c  = ref_reg[smp.key];
   assign cnt_c  = cnt_reg[smp.key];
   assign kst_c  = kst_reg[smp.key];
   assign ntim_c = ntim_reg[smp.key];
   assign ptim_c = ptim_reg[smp.key];
   assign dcnt_c = dcnt_reg[smp.key];
   assign calc_c = calc_reg[smp.key];

   assign sig_x = $signed({2'b00, smp.value});
   assign ref_x = $signed({2'b00, ref_c});
   assign nd_x  = $signed({{(SX-TH_W){1'b0}}, cfg.nthr});
   assign pd_x  = $signed({{(SX-TH_W){1'b0}}, cfg.pthr});
   assign nh_x  = $signed({{(SX-TH_W){1'b0}}, hyst_part(cfg.nthr, hn_reg)});
   assign ph_x  = $signed({{(SX-TH_W){1'b0}}, hyst_part(cfg.pthr, hp_reg)});
   // levels follow the live reference every sample
   assign neg_lvl  = ref_x - nd_x;
   assign neg_drop = neg_lvl + nh_x;
   assign pos_lvl  = ref_x + pd_x;
   assign pos_drop = pos_lvl - ph_x;
   assign below_n  = sig_x <= neg_lvl;
   assign still_n  = sig_x < neg_drop;
   assign above_p  = sig_x > pos_lvl;
   assign still_p  = sig_x > pos_drop;

   always_comb begin
      ref_n = ref_c;
      cnt_n = cnt_c;
      kst_n = kst_c;
      ntim_n = ntim_c;
      ptim_n = ptim_c;
      dcnt_n = dcnt_c;
      calc_n = calc_c;
      rate = 4'h0;
      neg_fire = 1'b0;
      pos_fire = 1'b0;
      case (kst_c)
         KS_CAL: begin
            ref_n = smp.value;
            cnt_n = 4'h0;
            ntim_n = '0;
            ptim_n = '0;
            dcnt_n = 4'h0;
            if (calc_c <= 4'h1) begin
               calc_n = 4'h0;
               kst_n = KS_IDLE;
            end else begin
               calc_n = calc_c - 4'h1;
            end
         end
         KS_ON: begin
            ptim_n = '0;
            if (cfg.integ == 4'h0) begin
               kst_n = KS_IDLE;
               cnt_n = 4'h0;
               ntim_n = '0;
            end else if (still_n) begin
               if (ntim_c != '1)
                  ntim_n = ntim_c + 1'b1;
               if (dly.ndly != '0 && ntim_n > dly.ndly) begin
                  neg_fire = 1'b1;
                  ref_n = smp.value;
                  cnt_n = 4'h0;
                  kst_n = KS_IDLE;
                  ntim_n = '0;
               end
            end else begin
               ntim_n = '0;
               cnt_n = cnt_c - 4'h1;
               if (cnt_c <= 4'h1) begin
                  cnt_n = 4'h0;
                  kst_n = KS_IDLE;
               end
            end
         end
         default: begin
            ntim_n = '0;
            if (cfg.integ == 4'h0) begin
               kst_n = KS_IDLE;
               cnt_n = 4'h0;
            end else if (below_n) begin
               if ({1'b0, cnt_c} + 5'h01 >= {1'b0, cfg.integ}) begin
                  kst_n = KS_ON;
                  cnt_n = cfg.integ;
               end else begin
                  kst_n = KS_PEND;
                  cnt_n = cnt_c + 4'h1;
               end
            end else begin
               kst_n = KS_IDLE;
               cnt_n = 4'h0;
            end
            if (dly.pdly != '0 && (above_p || (ptim_c != '0 && still_p))) begin
               if (ptim_c != '1)
                  ptim_n = ptim_c + 1'b1;
               if (ptim_n >= dly.pdly) begin
                  pos_fire = 1'b1;
                  ref_n = smp.value;
                  ptim_n = '0;
                  dcnt_n = 4'h0;
               end
            end else begin
               ptim_n = '0;
            end
            // drift held while a positive swing is being timed
            if (!pos_fire && ptim_n == '0 && kst_c == KS_IDLE && !below_n
                && !cfg.drift_off && smp.value != ref_c) begin
               rate = (smp.value > ref_c) ? cfg.drift_up
                                          : cfg.drift_dn;
               if (rate != 4'h0) begin
                  if ({1'b0, dcnt_c} + 5'h01 >= {1'b0, rate}) begin
                     dcnt_n = 4'h0;
                     ref_n = (smp.value > ref_c) ? ref_c + 1'b1
                                                 : ref_c - 1'b1;
                  end else begin
                     dcnt_n = dcnt_c + 4'h1;
                  end
               end
            end
         end
      endcase
   end

   // per-key state store; recalibration request wins over a sample
   always_ff @(posedge aclk) begin
      if (!aresetn || recal_req_reg) begin
         for (int k = 0; k < NKEY; k++) begin
            ref_reg[k] <= '0;
            cnt_reg[k] <= 4'h0;
            kst_reg[k] <= KS_CAL;
            ntim_reg[k] <= '0;
            ptim_reg[k] <= '0;
            dcnt_reg[k] <= 4'h0;
            calc_reg[k] <= CAL_BURSTS;
         end
      end else if (smp_valid) begin
         ref_reg[smp.key] <= ref_n;
         cnt_reg[smp.key] <= cnt_n;
         kst_reg[smp.key] <= kst_n;
         ntim_reg[smp.key] <= ntim_n;
         ptim_reg[smp.key] <= ptim_n;
         dcnt_reg[smp.key] <= dcnt_n;
         calc_reg[smp.key] <= calc_n;
      end
   end

   // status vectors
   always_ff @(posedge aclk) begin
      if (!aresetn || recal_req_reg) begin
         detect_reg <= '0;
         calib_reg <= '1;
      end else if (smp_valid) begin
         detect_reg[smp.key] <= (kst_n == KS_ON);
         calib_reg[smp.key] <= (kst_n == KS_CAL);
      end
   end

   assign detect_o = detect_reg;
   assign calib_o  = calib_reg;

   // configuration writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hn_reg <= CTRL_RST[CTRL_HN_LSB +: 2];
         hp_reg <= CTRL_RST[CTRL_HP_LSB +: 2];
         recal_req_reg <= 1'b0;
         for (int k = 0; k < NKEY; k++) begin
            kcfg_reg[k] <= KCFG_RST;
            kdly_reg[k] <= KDLY_RST;
         end
      end else begin
         recal_req_reg <= 1'b0;
         if (wr_fire && wr_rgn == RG_CTRL && wstrb_reg[0]) begin
            hn_reg <= wdata_reg[CTRL_HN_LSB +: 2];
            hp_reg <= wdata_reg[CTRL_HP_LSB +: 2];
            recal_req_reg <= wdata_reg[CTRL_RECAL_BIT];
         end
         if (wr_fire && wr_rgn == RG_KCFG)
            kcfg_reg[wr_key] <= merge(kcfg_reg[wr_key], wdata_reg, wstrb_reg);
         if (wr_fire && wr_rgn == RG_KDLY)
            kdly_reg[wr_key] <= merge(kdly_reg[wr_key], wdata_reg, wstrb_reg);
      end
   end

   // write channels taken in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            awaddr_reg <= s_axi_awaddr;
            aw_got_reg <= 1'b1;
            awready_reg <= 1'b0;
         end else if (!aw_got_reg && !bvalid_reg) begin
            awready_reg <= 1'b1;
         end
         if (s_axi_wvalid && wready_reg) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_got_reg <= 1'b1;
            wready_reg <= 1'b0;
         end else if (!w_got_reg && !bvalid_reg) begin
            wready_reg <= 1'b1;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_rgn == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
         case (decode(s_axi_araddr))
            RG_CTRL: begin
               rdata_reg[CTRL_HN_LSB +: 2] <= hn_reg;
               rdata_reg[CTRL_HP_LSB +: 2] <= hp_reg;
            end
            RG_DET:  rdata_reg[NKEY-1:0] <= detect_reg;
            RG_CAL:  rdata_reg[NKEY-1:0] <= calib_reg;
            RG_KCFG: rdata_reg <= kcfg_reg[s_axi_araddr[2 +: KEY_W]];
            RG_KDLY: rdata_reg <= kdly_reg[s_axi_araddr[2 +: KEY_W]];
            RG_KST:  rdata_reg <= {10'h000,
                                   kst_reg[s_axi_araddr[2 +: KEY_W]],
                                   cnt_reg[s_axi_araddr[2 +: KEY_W]],
                                   ref_reg[s_axi_araddr[2 +: KEY_W]]};
            default: rresp_reg <= RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_recal;
      recal_req_reg;
   endsequence
   sequence s_calibrating;
      kst_reg[0] == KS_CAL && calc_reg[0] == CAL_BURSTS;
   endsequence

   AST_DROP_BETWEEN: assert property (smp_valid |->
      neg_lvl <= neg_drop && neg_drop <= ref_x)
      else $error("drop-out level outside threshold and reference");
   AST_HYST_EIGHTH: assert property (hn_reg == H_EIGHTH |->
      neg_drop - neg_lvl == (nd_x >>> 3))
      else $error("eighth hysteresis wrong");
   AST_DRIFT_STEP: assert property (smp_valid && kst_c == KS_IDLE
      && !pos_fire |-> ref_n == ref_c || ref_n == ref_c + 1'b1
      || ref_n == ref_c - 1'b1)
      else $error("drift moved reference by more than a step");
   AST_NO_DRIFT_BELOW: assert property (smp_valid && below_n
      && (kst_c == KS_IDLE || kst_c == KS_PEND) |=>
      ref_reg[$past(smp.key)] == $past(ref_c))
      else $error("reference drifted during detection");
   AST_DRIFT_OFF: assert property (smp_valid && cfg.drift_off
      && kst_c == KS_IDLE && !pos_fire |-> ref_n == ref_c)
      else $error("disabled key drifted");
   AST_INTEG_CLEAR: assert property (smp_valid && kst_c == KS_PEND
      && !below_n |-> cnt_n == 4'h0 && kst_n == KS_IDLE)
      else $error("integrator not cleared");
   AST_CONFIRM: assert property (smp_valid && kst_c != KS_ON
      && kst_n == KS_ON |-> cnt_n == cfg.integ && cfg.integ != 4'h0)
      else $error("confirmed before target");
   AST_INTEG_ZERO: assert property (smp_valid && cfg.integ == 4'h0
      && kst_c != KS_CAL |-> kst_n == KS_IDLE)
      else $error("disabled key detected");
   AST_RELEASE: assert property (smp_valid && kst_c == KS_ON
      && kst_n == KS_IDLE && !neg_fire && cfg.integ != 4'h0 |->
      cnt_c <= 4'h1)
      else $error("key off before count reached zero");
   AST_NEG_RECAL: assert property (smp_valid && neg_fire |->
      ref_n == smp.value && cnt_n == 4'h0 && dly.ndly != '0)
      else $error("negative recalibration incomplete");
   AST_CAL_NINE: assert property (s_recal |=> s_calibrating)
      else $error("calibration not restarted with nine bursts");
   AST_BRESP_HOLD: assert property (bvalid_reg && !s_axi_bready |=>
      bvalid_reg && $stable(bresp_reg))
      else $error("write response dropped");
endmodule : tkd_touch_key

// [tkd_front_end.sv]
`timescale 1ns/1ps
module tkd_front_end
   import tkd_pkg::*;
(
   // clock
   input  wire logic  aclk,
   // conversion results toward the block
   output tkd_sample_s smp,
   output logic        smp_valid
);
   initial begin
      smp_valid = 1'b0;
      smp       = '0;
   end
   // idle value line flips so a stale sample never looks valid
   task automatic send(input int k, input int v);
      @(posedge aclk);
      smp_valid <= 1'b1;
      smp       <= {k[3:0], v[15:0]};
      @(posedge aclk);
      smp_valid <= 1'b0;
      smp.value <= ~v[15:0];
   endtask : send
endmodule : tkd_front_end

// [touch_key_detect_calibrate_bench.sv]
`timescale 1ns/1ps
module touch_key_detect_calibrate_bench;
   import tkd_pkg::*;
   logic              aclk, aresetn, smp_valid;
   tkd_sample_s       smp;
   logic [NKEY-1:0]   det, cal;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready;
   logic [31:0]       wdata, rdata, seed, d, ctl, kc[16], kd[16];
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   int                fails, n_checks, k, b, s, rf[16], ig[16], st[16];
   int                cb[16], pt[16], nt[16], dc[16];
   logic [31:0] cf[5] = '{32'h1412_0a14, 32'h1411_0a14, 32'h1411_0a14,
                          32'h1410_0a14, 32'h0411_ff14};
   logic [31:0] dl[5] = '{32'h0, 32'h0, 32'h0403, 32'h0, 32'h0};

   tkd_front_end fe (.aclk(aclk), .smp_valid(smp_valid), .smp(smp));
   tkd_touch_key dut (
      .aclk(aclk), .aresetn(aresetn), .smp_valid(smp_valid), .smp(smp),
      .detect_o(det), .calib_o(cal),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic test_done();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      n_checks++;
      if (v !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, v);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
      int t;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && t < 200);
      chk("bresp", e, bresp);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      int t;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         t++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && t < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rref(input int q);
      rd(ADDR_KST + 12'(4 * q));
      chk("reference", rf[q], {16'h0, d[15:0]});
   endtask : rref

   // reference model; the state before the sample gates drift and timers
   task automatic mdl(input int q, input int v);
      int nth, pth, tg, sh, hp, tch, ws, ps, rt;
      nth = kc[q][7:0];
      pth = kc[q][15:8];
      tg  = kc[q][19:16];
      sh  = (ctl[1:0] == 0) ? 3 : (ctl[1:0] == 1) ? 2 : 1;
      hp  = (ctl[3:2] == 0) ? 3 : (ctl[3:2] == 1) ? 2 : 1;
      if (cb[q] < 9) begin
         rf[q] = v;
         cb[q]++;
         st[q] = (cb[q] == 9) ? 1 : 0;
      end else begin
         ws = st[q];
         ps = (st[q] == 1 && ig[q] == 0);
         tch = (st[q] == 2) ? (v < rf[q] - nth + (nth >> sh)) : (v <= rf[q] - nth);
         if (tg == 0) ig[q] = 0;
         else if (tch && st[q] != 2) ig[q]++;
         else if (!tch && st[q] == 2) ig[q]--;
         else if (!tch) ig[q] = 0;
         if (tg != 0 && ig[q] >= tg) st[q] = 2;
         if (st[q] == 2 && ig[q] == 0) st[q] = 1;
         nt[q] = (ws == 2 && st[q] == 2) ? nt[q] + 1 : 0;
         if (kd[q][7:0] != 0 && nt[q] > kd[q][7:0]) begin
            rf[q] = v;
            ig[q] = 0;
            st[q] = 1;
            nt[q] = 0;
         end
         if (kd[q][15:8] != 0 && ws != 2
             && v > rf[q] + pth - ((pt[q] > 0) ? pth >> hp : 0)) pt[q]++;
         else pt[q] = 0;
         rt = (v > rf[q]) ? kc[q][23:20] : kc[q][27:24];
         if (pt[q] != 0 && pt[q] >= kd[q][15:8]) begin
            rf[q] = v;
            pt[q] = 0;
            dc[q] = 0;
         end else if (!kc[q][28] && ps && !tch && pt[q] == 0
                      && v != rf[q] && rt != 0) begin
            dc[q]++;
            if (dc[q] >= rt) begin
               dc[q] = 0;
               rf[q] = (v > rf[q]) ? rf[q] + 1 : rf[q] - 1;
            end
         end
      end
   endtask : mdl

   task automatic sc(input int q, input int v, input int n);
      repeat (n) begin
         fe.send(q, v);
         mdl(q, v);
         #1;
         chk("detect", 32'(st[q] == 2), 32'(det[q]));
         chk("calib", 32'(cb[q] < 9), 32'(cal[q]));
      end
   endtask : sc

   initial begin
      #200000;
      fails++;
      test_done();
   end

   initial begin
      {aresetn, awaddr, araddr, awvalid, wvalid, bready} = '0;
      {arvalid, rready, wdata} = '0;
      wstrb = 4'hf;
      seed  = 32'h10;
      ctl   = CTRL_RST;
      foreach (kc[i]) kc[i] = KCFG_RST;
      foreach (kd[i]) kd[i] = KDLY_RST;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk("calib", 32'hffff, 32'(cal));
      rd(ADDR_KCFG);
      chk("kcfg", KCFG_RST, d);
      rd(ADDR_KDLY + 12'h01c);
      chk("kdly", KDLY_RST, d);
      rd(12'h0fc);
      chk("rresp", RESP_SLVERR, r);
      wr(12'h0fc, 32'h1, RESP_SLVERR);
      // key 4 drifts up faster than down
      for (k = 0; k < 5; k++) begin
         wr(ADDR_KCFG + 12'(4 * k), cf[k], RESP_OKAY);
         wr(ADDR_KDLY + 12'(4 * k), dl[k], RESP_OKAY);
         kc[k] = cf[k];
         kd[k] = dl[k];
      end
      for (k = 0; k < 5; k++) begin
         b = 1000 + int'(xs() & 32'hff);
         sc(k, b, 9);
         rref(k);
      end
      sc(0, rf[0] - 20, 2);
      sc(0, rf[0] - 20, 33);
      sc(0, rf[0], 2);
      sc(0, rf[0] - 20, 1);
      sc(0, rf[0], 1);
      sc(0, rf[0] - 20, 1);
      sc(0, rf[0] + 50, 6);
      rref(0);
      sc(3, rf[3] - 40, 4);
      for (s = 0; s < 3; s++) begin
         ctl = 32'(s | ((2 - s) << 2));
         wr(ADDR_CTRL, ctl, RESP_OKAY);
         b = rf[1] - 20 + (20 >> (3 - s));
         sc(1, rf[1] - 20, 1);
         sc(1, b - 1, 1);
         sc(1, b, 1);
      end
      sc(2, rf[2] - 30, 5);
      rref(2);
      sc(2, rf[2] + 30, 4);
      rref(2);
      sc(4, rf[4] + 5, 3);
      rref(4);
      sc(4, rf[4] - 20, 1);
      sc(4, rf[4], 1);
      sc(4, rf[4] - 5, 4);
      rref(4);
      kc[4] = 32'h1411_ff14;
      wr(ADDR_KCFG + 12'h010, kc[4], RESP_OKAY);
      sc(4, rf[4] + 9, 2);
      rref(4);
      ctl = 32'h10;
      wr(ADDR_CTRL, ctl, RESP_OKAY);
      foreach (cb[i]) begin
         cb[i] = 0;
         ig[i] = 0;
         dc[i] = 0;
      end
      #1;
      chk("calib", 32'hffff, 32'(cal));
      sc(4, 1100, 9);
      rref(4);
      test_done();
   end
endmodule : touch_key_detect_calibrate_bench
